// file: multicast_capability_info_consts.vh
// register offsets, field positions, reset values and constants of the multicast capability bank
`ifndef MULTICAST_CAPABILITY_INFO_CONSTS_VH
`define MULTICAST_CAPABILITY_INFO_CONSTS_VH

// register offsets on the register port
`define MULTICAST_CAPABILITY_INFO_OFS_HEADER      12'h330
`define MULTICAST_CAPABILITY_INFO_OFS_INFO        12'h334
`define MULTICAST_CAPABILITY_INFO_OFS_CONTROL     12'h336
`define MULTICAST_CAPABILITY_INFO_OFS_BASE_LOW    12'h338
`define MULTICAST_CAPABILITY_INFO_OFS_BASE_HIGH   12'h33c

// capability header fields
`define MULTICAST_CAPABILITY_INFO_ID_LSB          0
`define MULTICAST_CAPABILITY_INFO_ID_MSB          15
`define MULTICAST_CAPABILITY_INFO_VER_LSB         16
`define MULTICAST_CAPABILITY_INFO_VER_MSB         19
`define MULTICAST_CAPABILITY_INFO_NXT_LSB         20
`define MULTICAST_CAPABILITY_INFO_NXT_MSB         31
`define MULTICAST_CAPABILITY_INFO_ID_VALUE        16'h0012
`define MULTICAST_CAPABILITY_INFO_VER_VALUE       4'h1
`define MULTICAST_CAPABILITY_INFO_NXT_RESET       12'h000

// capability info fields
`define MULTICAST_CAPABILITY_INFO_SUP_LSB         0
`define MULTICAST_CAPABILITY_INFO_SUP_MSB         5
`define MULTICAST_CAPABILITY_INFO_CRC_BIT         15
`define MULTICAST_CAPABILITY_INFO_SUP_RESET       6'h1f
`define MULTICAST_CAPABILITY_INFO_CRC_RESET       1'h1

// control fields
`define MULTICAST_CAPABILITY_INFO_CNT_LSB         0
`define MULTICAST_CAPABILITY_INFO_CNT_MSB         5
`define MULTICAST_CAPABILITY_INFO_EN_BIT          15
`define MULTICAST_CAPABILITY_INFO_CNT_RESET       6'h00
`define MULTICAST_CAPABILITY_INFO_EN_RESET        1'h0

// base low fields
`define MULTICAST_CAPABILITY_INFO_IDX_LSB         0
`define MULTICAST_CAPABILITY_INFO_IDX_MSB         5
`define MULTICAST_CAPABILITY_INFO_BLO_LSB         12
`define MULTICAST_CAPABILITY_INFO_BLO_MSB         31
`define MULTICAST_CAPABILITY_INFO_IDX_RESET       6'h00
`define MULTICAST_CAPABILITY_INFO_BLO_RESET       20'h00000
`define MULTICAST_CAPABILITY_INFO_BHI_RESET       32'h00000000

// smallest legal index position while enabled
`define MULTICAST_CAPABILITY_INFO_IDX_MIN         6'h0c

`endif

// file: multicast_capability_info_regs.v
// register bank of the multicast extended capability with group window decode
//
// Behaviour
// - the header's low sixteen bits read back the fixed capability identifier 0x12.
// - header bits 19 to 16 read back the fixed capability version 0x1.
// - header bits 31 to 20 hold the next capability offset, writable only while locking allows, zero ends the chain.
// - the supported group field resets to 0x1f (32 groups), may be raised during initial load, groups equal field plus one.
// - capability bit 15 is a lockable crc regeneration flag that resets to one.
// - control bits 5 to 0 are read-write, reset to zero, and give the enabled group count as field plus one.
// - control bit 15 is read-write, resets to zero, and enables multicast for the owning partition.
// - base low bits 5 to 0 are read-write and name the address bit holding the group number's low bit.
// - base low bits 31 to 12 are read-write, reset to zero, and give address bits 12 to 31 of the base.
// - the base high register is read-write on all 32 bits, resets to zero, and gives address bits 32 to 63.
// - per-group vector bits whose index lies above the enabled count are ignored.
//
// Design decision made here: the address-and-strobe port.

`include "multicast_capability_info_consts.vh"

module multicast_capability_info_regs
#(
  parameter [11:0] NEXT_OFFSET_DEFAULT = `MULTICAST_CAPABILITY_INFO_NXT_RESET,
  parameter        ADDR_WIDTH          = 12,
  parameter        GROUPS              = 64
)
(
  input  wire                  sys_clk,
  input  wire                  reset,
  input  wire [ADDR_WIDTH-1:0] reg_addr,
  input  wire [31:0]           reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  output reg  [31:0]           reg_rdata_r,
  input  wire                  init_cfg_active,
  input  wire                  probe_valid,
  input  wire [63:0]           probe_addr,
  output reg                   group_cast_enable_r,
  output reg  [5:0]            enabled_group_count_r,
  output reg  [5:0]            supported_group_count_r,
  output reg                   crc_regen_supported_r,
  output reg  [5:0]            group_index_position_r,
  output reg  [63:0]           group_base_addr_r,
  output reg  [GROUPS-1:0]     group_active_mask_r,
  output reg                   cfg_conflict_r,
  output reg                   probe_done_r,
  output reg                   probe_hit_r,
  output reg  [5:0]            probe_group_r
);

  // stored fields
  reg  [11:0] next_capability_offset_r;
  reg  [5:0]  supported_group_count_nxt;
  reg         crc_regen_supported_nxt;
  reg  [19:0] group_base_low_bits_r;
  reg  [31:0] group_base_high_bits_r;
  reg  [5:0]  group_index_position_nxt;
  reg  [5:0]  enabled_group_count_nxt;
  reg         group_cast_enable_nxt;

  // register decode
  wire        sel_header;
  wire        sel_info;
  wire        sel_control;
  wire        sel_base_low;
  wire        sel_base_high;
  wire        wr_header;
  wire        wr_info;
  wire        wr_control;
  wire        wr_base_low;
  wire        wr_base_high;
  wire        lock_open;

  // read assembly
  wire [31:0] header_word;
  wire [31:0] info_word;
  wire [31:0] control_word;
  wire [31:0] base_low_word;
  reg  [31:0] read_nxt;

  // window decode
  wire [63:0] base_addr;
  wire [63:0] probe_offset;
  wire [63:0] probe_index;
  wire        probe_above;
  wire        probe_in_range;
  wire        probe_hit_nxt;

  // address comparisons
  assign sel_header    = (reg_addr == `MULTICAST_CAPABILITY_INFO_OFS_HEADER);
  assign sel_info      = (reg_addr == `MULTICAST_CAPABILITY_INFO_OFS_INFO);
  assign sel_control   = (reg_addr == `MULTICAST_CAPABILITY_INFO_OFS_CONTROL);
  assign sel_base_low  = (reg_addr == `MULTICAST_CAPABILITY_INFO_OFS_BASE_LOW);
  assign sel_base_high = (reg_addr == `MULTICAST_CAPABILITY_INFO_OFS_BASE_HIGH);

  // write strobes per register
  assign wr_header    = reg_wr && sel_header;
  assign wr_info      = reg_wr && sel_info;
  assign wr_control   = reg_wr && sel_control;
  assign wr_base_low  = reg_wr && sel_base_low;
  assign wr_base_high = reg_wr && sel_base_high;

  // lockable fields open only while the initial configuration loads
  assign lock_open = init_cfg_active;

  // next capability offset, lockable
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      next_capability_offset_r <= NEXT_OFFSET_DEFAULT;
    end
    else if (wr_header && lock_open)
    begin
      next_capability_offset_r <= reg_wdata[`MULTICAST_CAPABILITY_INFO_NXT_MSB:`MULTICAST_CAPABILITY_INFO_NXT_LSB];
    end
  end

  // capability info next values, lockable fields only
  always @*
  begin
    supported_group_count_nxt = supported_group_count_r;
    crc_regen_supported_nxt   = crc_regen_supported_r;
    if (wr_info && lock_open)
    begin
      supported_group_count_nxt = reg_wdata[`MULTICAST_CAPABILITY_INFO_SUP_MSB:`MULTICAST_CAPABILITY_INFO_SUP_LSB];
      crc_regen_supported_nxt   = reg_wdata[`MULTICAST_CAPABILITY_INFO_CRC_BIT];
    end
  end

  // capability info storage
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      supported_group_count_r <= `MULTICAST_CAPABILITY_INFO_SUP_RESET;
      crc_regen_supported_r   <= `MULTICAST_CAPABILITY_INFO_CRC_RESET;
    end
    else
    begin
      supported_group_count_r <= supported_group_count_nxt;
      crc_regen_supported_r   <= crc_regen_supported_nxt;
    end
  end

  // control next values, plain read-write
  always @*
  begin
    enabled_group_count_nxt = enabled_group_count_r;
    group_cast_enable_nxt   = group_cast_enable_r;
    if (wr_control)
    begin
      enabled_group_count_nxt = reg_wdata[`MULTICAST_CAPABILITY_INFO_CNT_MSB:`MULTICAST_CAPABILITY_INFO_CNT_LSB];
      group_cast_enable_nxt   = reg_wdata[`MULTICAST_CAPABILITY_INFO_EN_BIT];
    end
  end

  // control storage
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      enabled_group_count_r <= `MULTICAST_CAPABILITY_INFO_CNT_RESET;
      group_cast_enable_r   <= `MULTICAST_CAPABILITY_INFO_EN_RESET;
    end
    else
    begin
      enabled_group_count_r <= enabled_group_count_nxt;
      group_cast_enable_r   <= group_cast_enable_nxt;
    end
  end

  // base low next value; bits 11 to 6 are not stored
  always @*
  begin
    group_index_position_nxt = group_index_position_r;
    if (wr_base_low)
    begin
      group_index_position_nxt = reg_wdata[`MULTICAST_CAPABILITY_INFO_IDX_MSB:`MULTICAST_CAPABILITY_INFO_IDX_LSB];
    end
  end

  // base address storage
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      group_index_position_r <= `MULTICAST_CAPABILITY_INFO_IDX_RESET;
      group_base_low_bits_r  <= `MULTICAST_CAPABILITY_INFO_BLO_RESET;
      group_base_high_bits_r <= `MULTICAST_CAPABILITY_INFO_BHI_RESET;
    end
    else
    begin
      group_index_position_r <= group_index_position_nxt;
      if (wr_base_low)
      begin
        group_base_low_bits_r <= reg_wdata[`MULTICAST_CAPABILITY_INFO_BLO_MSB:`MULTICAST_CAPABILITY_INFO_BLO_LSB];
      end
      if (wr_base_high)
      begin
        group_base_high_bits_r <= reg_wdata;
      end
    end
  end

  // read words, constants and zeros in fixed and reserved bits
  assign header_word   = {next_capability_offset_r, `MULTICAST_CAPABILITY_INFO_VER_VALUE, `MULTICAST_CAPABILITY_INFO_ID_VALUE};
  assign info_word     = {16'h0000, crc_regen_supported_r, 9'h000, supported_group_count_r};
  assign control_word  = {16'h0000, group_cast_enable_r, 9'h000, enabled_group_count_r};
  assign base_low_word = {group_base_low_bits_r, 6'h00, group_index_position_r};

  // read multiplexer, unmapped offsets read zero
  always @*
  begin
    read_nxt = 32'h00000000;
    if (reg_rd)
    begin
      case (1'b1)
        sel_header:    read_nxt = header_word;
        sel_info:      read_nxt = info_word;
        sel_control:   read_nxt = control_word;
        sel_base_low:  read_nxt = base_low_word;
        sel_base_high: read_nxt = group_base_high_bits_r;
        default:       read_nxt = 32'h00000000;
      endcase
    end
  end

  // read data stands one cycle after the strobe only
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      reg_rdata_r <= 32'h00000000;
    end
    else
    begin
      reg_rdata_r <= read_nxt;
    end
  end

  // full base address as seen by the forwarding logic
  assign base_addr = {group_base_high_bits_r, group_base_low_bits_r, 12'h000};

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      group_base_addr_r <= 64'h0000000000000000;
    end
    else
    begin
      group_base_addr_r <= base_addr;
    end
  end

  // one mask bit per group, set only for enabled groups up to the count
  genvar g;
  generate
    for (g = 0; g < GROUPS; g = g + 1)
    begin : grp_mask
      always @(posedge sys_clk)
      begin
        if (reset)
        begin
          group_active_mask_r[g] <= 1'b0;
        end
        else
        begin
          group_active_mask_r[g] <= group_cast_enable_r && (g <= enabled_group_count_r);
        end
      end
    end
  endgenerate

  // flags a setup that software was told to avoid
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      cfg_conflict_r <= 1'b0;
    end
    else
    begin
      cfg_conflict_r <= group_cast_enable_r &&
                        ((enabled_group_count_r > supported_group_count_r) ||
                         (group_index_position_r < `MULTICAST_CAPABILITY_INFO_IDX_MIN));
    end
  end

  // group window decode of a probe address; base bits under the group field are assumed zero
  assign probe_offset   = probe_addr - base_addr;
  assign probe_index    = probe_offset >> group_index_position_r;
  assign probe_above    = (probe_addr >= base_addr);
  assign probe_in_range = (probe_index <= {58'h0, enabled_group_count_r});
  assign probe_hit_nxt  = probe_valid && group_cast_enable_r && probe_above && probe_in_range;

  // probe answer one cycle after the request
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      probe_done_r  <= 1'b0;
      probe_hit_r   <= 1'b0;
      probe_group_r <= 6'h00;
    end
    else
    begin
      probe_done_r  <= probe_valid;
      probe_hit_r   <= probe_hit_nxt;
      probe_group_r <= probe_hit_nxt ? probe_index[5:0] : 6'h00;
    end
  end

endmodule

// file: multicast_capability_info_regs_properties.sv
// assertion checker for the multicast capability register bank
module multicast_capability_info_checker
#(
  parameter ADDR_WIDTH = 12,
  parameter GROUPS     = 64
)
(
  input logic                  sys_clk,
  input logic                  reset,
  input logic [ADDR_WIDTH-1:0] reg_addr,
  input logic [31:0]           reg_wdata,
  input logic                  reg_wr,
  input logic                  reg_rd,
  input logic [31:0]           reg_rdata_r,
  input logic                  init_cfg_active,
  input logic                  probe_valid,
  input logic                  group_cast_enable_r,
  input logic [5:0]            enabled_group_count_r,
  input logic [5:0]            supported_group_count_r,
  input logic                  crc_regen_supported_r,
  input logic [5:0]            group_index_position_r,
  input logic [63:0]           group_base_addr_r,
  input logic [GROUPS-1:0]     group_active_mask_r,
  input logic                  cfg_conflict_r,
  input logic                  probe_done_r,
  input logic                  probe_hit_r,
  input logic [5:0]            probe_group_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (reset);
  // writes to the control and base registers
  sequence ctl_wr_s; reg_wr && reg_addr == 12'h336; endsequence
  sequence low_wr_s; reg_wr && reg_addr == 12'h338; endsequence
  sequence high_wr_s; reg_wr && reg_addr == 12'h33c; endsequence
  // read data, fields and derived outputs
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata_r == 32'h0)
    else $error("read data not zero outside a read");
  header_fixed_a: assert property (reg_rd && reg_addr == 12'h330 |=> reg_rdata_r[19:0] == 20'h10012)
    else $error("header low bits wrong");
  info_read_a: assert property (reg_rd && reg_addr == 12'h334 |=>
    reg_rdata_r == {16'h0, $past(crc_regen_supported_r), 9'h0, $past(supported_group_count_r)})
    else $error("info read wrong");
  lock_hold_a: assert property (reg_wr && !init_cfg_active |=>
    $stable(supported_group_count_r) && $stable(crc_regen_supported_r))
    else $error("locked field changed");
  ctl_write_a: assert property (ctl_wr_s |=>
    enabled_group_count_r == $past(reg_wdata[5:0]) && group_cast_enable_r == $past(reg_wdata[15]))
    else $error("control write not taken");
  idx_write_a: assert property (low_wr_s |=> group_index_position_r == $past(reg_wdata[5:0]))
    else $error("index position not taken");
  base_low_a: assert property (low_wr_s ##1 !(reg_wr && reg_addr == 12'h338) |=>
    group_base_addr_r[31:0] == {$past(reg_wdata[31:12], 2), 12'h000})
    else $error("base low wrong");
  base_high_a: assert property (high_wr_s ##1 !(reg_wr && reg_addr == 12'h33c) |=>
    group_base_addr_r[63:32] == $past(reg_wdata, 2))
    else $error("base high wrong");
  mask_follow_a: assert property (1'b1 |=> group_active_mask_r == ($past(group_cast_enable_r) ?
    ({GROUPS{1'b1}} >> (GROUPS - 1 - $past(enabled_group_count_r))) : {GROUPS{1'b0}}))
    else $error("active mask wrong");
  probe_off_a: assert property (probe_valid && !group_cast_enable_r |=>
    probe_done_r && !probe_hit_r && probe_group_r == 6'h00)
    else $error("probe hit while disabled");
  cfg_conflict_a: assert property (1'b1 |=> cfg_conflict_r == $past(group_cast_enable_r &&
    (enabled_group_count_r > supported_group_count_r || group_index_position_r < 6'h0c)))
    else $error("conflict flag wrong");
endmodule

bind multicast_capability_info_regs multicast_capability_info_checker #(.ADDR_WIDTH(ADDR_WIDTH), .GROUPS(GROUPS)) chk_u (
  .sys_clk                 (sys_clk),
  .reset                   (reset),
  .reg_addr                (reg_addr),
  .reg_wdata               (reg_wdata),
  .reg_wr                  (reg_wr),
  .reg_rd                  (reg_rd),
  .reg_rdata_r             (reg_rdata_r),
  .init_cfg_active         (init_cfg_active),
  .probe_valid             (probe_valid),
  .group_cast_enable_r     (group_cast_enable_r),
  .enabled_group_count_r   (enabled_group_count_r),
  .supported_group_count_r (supported_group_count_r),
  .crc_regen_supported_r   (crc_regen_supported_r),
  .group_index_position_r  (group_index_position_r),
  .group_base_addr_r       (group_base_addr_r),
  .group_active_mask_r     (group_active_mask_r),
  .cfg_conflict_r          (cfg_conflict_r),
  .probe_done_r            (probe_done_r),
  .probe_hit_r             (probe_hit_r),
  .probe_group_r           (probe_group_r)
);

// file: test_multicast_capability_regs.sv
// self-checking testbench of the multicast capability register bank
module test_multicast_capability_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] e; logic [31:0] r;} multicast_capability_info_row_t;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        init_cfg_active = 1'b0;
  logic        probe_valid = 1'b0;
  logic [63:0] probe_addr = 64'h0;
  logic [31:0] reg_rdata_r;
  logic        group_cast_enable_r;
  logic [5:0]  enabled_group_count_r;
  logic [5:0]  supported_group_count_r;
  logic        crc_regen_supported_r;
  logic [5:0]  group_index_position_r;
  logic [63:0] group_base_addr_r;
  logic [63:0] group_active_mask_r;
  logic        cfg_conflict_r;
  logic        probe_done_r;
  logic        probe_hit_r;
  logic [5:0]  probe_group_r;
  int          err_total = 0;
  int          checks_done = 0;
  // offset, write data, value read back after it, reset value
  multicast_capability_info_row_t  rows [6] = '{{12'h330, 32'hfff00000, 32'h00010012, 32'h00010012},
    {12'h334, 32'h00000000, 32'h0000801f, 32'h0000801f}, {12'h336, 32'hffff7fdf, 32'h0000001f, 32'h0},
    {12'h338, 32'hffffffff, 32'hfffff03f, 32'h0}, {12'h33c, 32'ha5a5a5a5, 32'ha5a5a5a5, 32'h0},
    {12'h320, 32'hffffffff, 32'h0, 32'h0}};

  multicast_capability_info_regs dut_u (
    .sys_clk                 (sys_clk),
    .reset                   (reset),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata_r             (reg_rdata_r),
    .init_cfg_active         (init_cfg_active),
    .probe_valid             (probe_valid),
    .probe_addr              (probe_addr),
    .group_cast_enable_r     (group_cast_enable_r),
    .enabled_group_count_r   (enabled_group_count_r),
    .supported_group_count_r (supported_group_count_r),
    .crc_regen_supported_r   (crc_regen_supported_r),
    .group_index_position_r  (group_index_position_r),
    .group_base_addr_r       (group_base_addr_r),
    .group_active_mask_r     (group_active_mask_r),
    .cfg_conflict_r          (cfg_conflict_r),
    .probe_done_r            (probe_done_r),
    .probe_hit_r             (probe_hit_r),
    .probe_group_r           (probe_group_r)
  );

  always #4 sys_clk = ~sys_clk;

  // compare and count
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one register port cycle
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask

  // read and compare the data of the following cycle
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, 12'h000, 32'h0);
    @(negedge sys_clk);
    check("read data", 64'(reg_rdata_r), 64'(exp));
  endtask

  // one decode request and its answer
  task automatic probe(input logic [63:0] a, input logic hit, input logic [5:0] grp);
    @(posedge sys_clk);
    probe_valid <= 1'b1;
    probe_addr <= a;
    @(posedge sys_clk);
    probe_valid <= 1'b0;
    probe_addr <= ~a;
    @(negedge sys_clk);
    check("probe done", 64'(probe_done_r), 64'h1);
    check("probe hit", 64'(probe_hit_r), 64'(hit));
    check("probe group", 64'(probe_group_r), 64'(grp));
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rows[i]) rd(rows[i].a, rows[i].r);
    $display("test reset values done");
    foreach (rows[i])
    begin
      bus(1'b1, 1'b0, rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    $display("test table done");
    @(posedge sys_clk);
    init_cfg_active <= 1'b1;
    bus(1'b1, 1'b0, 12'h334, 32'h0000003f);
    bus(1'b1, 1'b0, 12'h330, 32'habc00000);
    rd(12'h334, 32'h0000003f);
    rd(12'h330, 32'habc10012);
    check("max groups", 64'(supported_group_count_r), 64'h3f);
    @(posedge sys_clk);
    init_cfg_active <= 1'b0;
    bus(1'b1, 1'b0, 12'h334, 32'h0000801f);
    rd(12'h334, 32'h0000003f);
    $display("test initial load done");
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(12'h334, 32'h0000801f);
    rd(12'h330, 32'h00010012);
    $display("test second reset done");
    bus(1'b1, 1'b0, 12'h33c, 32'h1);
    bus(1'b1, 1'b0, 12'h338, 32'h0000000c);
    bus(1'b1, 1'b0, 12'h336, 32'h00008003);
    bus(1'b0, 1'b0, 12'h000, 32'h0);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("active mask", group_active_mask_r, 64'hf);
    check("base address", group_base_addr_r, 64'h1_0000_0000);
    check("enable", 64'(group_cast_enable_r), 64'h1);
    check("group count", 64'(enabled_group_count_r), 64'h3);
    check("index position", 64'(group_index_position_r), 64'hc);
    check("crc flag", 64'(crc_regen_supported_r), 64'h1);
    rd(12'h336, 32'h00008003);
    probe(64'h1_0000_2000, 1'b1, 6'h2);
    probe(64'h1_0000_3fff, 1'b1, 6'h3);
    probe(64'h1_0000_4000, 1'b0, 6'h0);
    bus(1'b1, 1'b0, 12'h336, 32'h3);
    bus(1'b0, 1'b0, 12'h000, 32'h0);
    probe(64'h1_0000_2000, 1'b0, 6'h0);
    bus(1'b1, 1'b0, 12'h338, 32'h0);
    bus(1'b1, 1'b0, 12'h336, 32'h00008003);
    bus(1'b0, 1'b0, 12'h000, 32'h0);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("conflict", 64'(cfg_conflict_r), 64'h1);
    $display("test decode done");
    report_and_stop();
  end
endmodule
